// ---- rtl/mib_statistics_counters.sv ----
// Statistics counters of a three-port switch with indirect host read access.
`timescale 1ns/1ns
`default_nettype none
module mib_statistics_counters #(
	parameter int NUM_PORTS = 3
) (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_clk_en,
	input  wire logic                        i_long_frame_en,
	input  wire logic                        i_ctrl_wr,
	input  wire logic [15:0]                 i_ctrl_data,
	input  wire logic [NUM_PORTS-1:0]        i_rx_done,
	input  wire logic [NUM_PORTS-1:0][11:0]  i_rx_len,
	input  wire logic [NUM_PORTS-1:0]        i_rx_crc_ok,
	input  wire logic [NUM_PORTS-1:0]        i_rx_sym_err,
	input  wire logic [NUM_PORTS-1:0]        i_rx_odd_bits,
	input  wire logic [NUM_PORTS-1:0]        i_rx_high_prio,
	input  wire logic [NUM_PORTS-1:0]        i_rx_bcast,
	input  wire logic [NUM_PORTS-1:0]        i_rx_mcast,
	input  wire logic [NUM_PORTS-1:0]        i_rx_ctrl_type,
	input  wire logic [NUM_PORTS-1:0]        i_rx_pause_fields,
	input  wire logic [NUM_PORTS-1:0]        i_tx_done,
	input  wire logic [NUM_PORTS-1:0][11:0]  i_tx_len,
	input  wire logic [NUM_PORTS-1:0]        i_tx_ok,
	input  wire logic [NUM_PORTS-1:0]        i_tx_high_prio,
	input  wire logic [NUM_PORTS-1:0]        i_tx_bcast,
	input  wire logic [NUM_PORTS-1:0]        i_tx_mcast,
	input  wire logic [NUM_PORTS-1:0]        i_tx_pause,
	input  wire logic [NUM_PORTS-1:0][3:0]   i_tx_coll_count,
	input  wire logic [NUM_PORTS-1:0]        i_tx_deferred,
	input  wire logic [NUM_PORTS-1:0]        i_tx_excessive,
	input  wire logic [NUM_PORTS-1:0]        i_tx_collision,
	input  wire logic [NUM_PORTS-1:0]        i_tx_late_coll,
	input  wire logic [NUM_PORTS-1:0]        i_tx_drop,
	input  wire logic [NUM_PORTS-1:0]        i_rx_drop,
	output logic      [15:0]                 o_indirect_data_low_word,
	output logic      [15:0]                 o_indirect_data_high_word,
	output logic                             o_read_done
);
	localparam int NDROP = 2 * NUM_PORTS;
	localparam int CW    = mib_pkg::COUNTERS;
	localparam int AW    = mib_pkg::AMT_W;

	typedef struct packed {
		logic                                   pend;
		logic                                   is_port;
		logic                                   is_drop;
		logic [1:0]                             port;
		logic [2:0]                             drop_idx;
		logic [15:0]                            lo;
		logic [15:0]                            hi;
		logic                                   done;
		logic [NDROP-1:0][mib_pkg::DROP_W-1:0]  drop;
	} main_state_type;

	main_state_type st_q;
	main_state_type st_d;

	if (NUM_PORTS < 1 || NUM_PORTS > 3) begin : g_bad
		$error("mib_statistics_counters: NUM_PORTS must be 1 to 3");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode.

	logic                         take;
	logic [mib_pkg::ADDR_W-1:0]   addr;
	logic                         addr_port;
	logic                         addr_drop;
	logic [NUM_PORTS-1:0]         rd_en;
	logic [11:0]                  max_len;
	logic [NUM_PORTS-1:0][31:0]   bank_data;
	logic [NUM_PORTS-1:0][CW-1:0][AW-1:0] inc;

	always_comb begin
		take = i_ctrl_wr && i_ctrl_data[mib_pkg::CTRL_READ_BIT]
			&& i_ctrl_data[mib_pkg::CTRL_TABLE_LSB +: 2] == mib_pkg::CTRL_TABLE_MIB;
		addr = i_ctrl_data[mib_pkg::ADDR_W-1:0];
		addr_port = addr < mib_pkg::ADDR_W'(NUM_PORTS * mib_pkg::PORT_SPAN);
		addr_drop = addr >= mib_pkg::DROP_BASE
			&& addr < mib_pkg::DROP_BASE + mib_pkg::ADDR_W'(NDROP);
		max_len = i_long_frame_en ? mib_pkg::LEN_LONG_MAX : mib_pkg::LEN_STD_MAX;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-port event classification and counter banks.

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		always_comb begin
			logic [11:0] len;
			logic        legal;
			logic        bad;
			logic        good;
			logic        tgood;
			len = i_rx_len[p];
			legal = len >= mib_pkg::LEN_MIN && len <= max_len;
			bad = !i_rx_crc_ok[p] || i_rx_sym_err[p] || i_rx_odd_bits[p];
			good = i_rx_done[p] && legal && !bad;
			tgood = i_tx_done[p] && i_tx_ok[p];
			inc[p] = '0;
			inc[p][mib_pkg::OFF_RX_LO_OCT] = (i_rx_done[p] && !i_rx_high_prio[p]) ? len : '0;
			inc[p][mib_pkg::OFF_RX_HI_OCT] = (i_rx_done[p] && i_rx_high_prio[p]) ? len : '0;
			inc[p][mib_pkg::OFF_RX_UNDER] = AW'(i_rx_done[p] && len < mib_pkg::LEN_MIN && !bad);
			inc[p][mib_pkg::OFF_RX_FRAG] = AW'(i_rx_done[p] && len < mib_pkg::LEN_MIN && bad);
			inc[p][mib_pkg::OFF_RX_OVER] = AW'(i_rx_done[p] && len > max_len
				&& len <= mib_pkg::LEN_LONG_MAX && !bad);
			inc[p][mib_pkg::OFF_RX_LONGERR] = AW'(i_rx_done[p] && len > max_len && bad);
			inc[p][mib_pkg::OFF_RX_SYMBOL] = AW'(i_rx_done[p] && legal && i_rx_sym_err[p]);
			inc[p][mib_pkg::OFF_RX_CRC] = AW'(i_rx_done[p] && legal && !i_rx_sym_err[p]
				&& !i_rx_crc_ok[p] && !i_rx_odd_bits[p]);
			inc[p][mib_pkg::OFF_RX_ALIGN] = AW'(i_rx_done[p] && legal && !i_rx_sym_err[p]
				&& !i_rx_crc_ok[p] && i_rx_odd_bits[p]);
			inc[p][mib_pkg::OFF_RX_CTRL] = AW'(i_rx_done[p] && i_rx_ctrl_type[p]);
			inc[p][mib_pkg::OFF_RX_PAUSE] = AW'(good && i_rx_ctrl_type[p]
				&& i_rx_pause_fields[p]);
			inc[p][mib_pkg::OFF_RX_BCAST] = AW'(good && i_rx_bcast[p]);
			inc[p][mib_pkg::OFF_RX_MCAST] = AW'(good && i_rx_mcast[p] && !i_rx_bcast[p]
				&& !i_rx_ctrl_type[p]);
			inc[p][mib_pkg::OFF_RX_UCAST] = AW'(good && !i_rx_mcast[p] && !i_rx_bcast[p]);
			inc[p][mib_pkg::OFF_RX_BIN64] = AW'(i_rx_done[p] && len == mib_pkg::LEN_MIN);
			inc[p][mib_pkg::OFF_RX_BIN64+1] = AW'(i_rx_done[p] && len > mib_pkg::LEN_MIN
				&& len <= mib_pkg::LEN_127);
			inc[p][mib_pkg::OFF_RX_BIN64+2] = AW'(i_rx_done[p] && len > mib_pkg::LEN_127
				&& len <= mib_pkg::LEN_255);
			inc[p][mib_pkg::OFF_RX_BIN64+3] = AW'(i_rx_done[p] && len > mib_pkg::LEN_255
				&& len <= mib_pkg::LEN_511);
			inc[p][mib_pkg::OFF_RX_BIN64+4] = AW'(i_rx_done[p] && len > mib_pkg::LEN_511
				&& len <= mib_pkg::LEN_1023);
			inc[p][mib_pkg::OFF_RX_BIN64+5] = AW'(i_rx_done[p] && len > mib_pkg::LEN_1023
				&& len <= max_len);
			inc[p][mib_pkg::OFF_TX_LO_OCT] = (tgood && !i_tx_high_prio[p]) ? i_tx_len[p] : '0;
			inc[p][mib_pkg::OFF_TX_HI_OCT] = (tgood && i_tx_high_prio[p]) ? i_tx_len[p] : '0;
			inc[p][mib_pkg::OFF_TX_LATE] = AW'(i_tx_late_coll[p]);
			inc[p][mib_pkg::OFF_TX_PAUSE] = AW'(tgood && i_tx_pause[p]);
			inc[p][mib_pkg::OFF_TX_BCAST] = AW'(tgood && i_tx_bcast[p]);
			inc[p][mib_pkg::OFF_TX_MCAST] = AW'(tgood && i_tx_mcast[p] && !i_tx_bcast[p]
				&& !i_tx_pause[p]);
			inc[p][mib_pkg::OFF_TX_UCAST] = AW'(tgood && !i_tx_mcast[p] && !i_tx_bcast[p]);
			inc[p][mib_pkg::OFF_TX_DEFER] = AW'(i_tx_done[p] && i_tx_deferred[p]);
			inc[p][mib_pkg::OFF_TX_COLL] = AW'(i_tx_collision[p]);
			inc[p][mib_pkg::OFF_TX_EXCESS] = AW'(i_tx_done[p] && i_tx_excessive[p]);
			inc[p][mib_pkg::OFF_TX_SINGLE] = AW'(tgood && i_tx_coll_count[p] == 4'h1);
			inc[p][mib_pkg::OFF_TX_MULTI] = AW'(tgood && i_tx_coll_count[p] > 4'h1);
		end

		assign rd_en[p] = take && addr_port && addr[6:5] == 2'(p);

		mib_counter_bank #(
			.COUNTERS (CW),
			.CNT_W    (mib_pkg::COUNT_W),
			.AMT_W    (AW)
		) u_bank (
			.i_core_clk (i_core_clk),
			.i_reset_n  (i_reset_n),
			.i_clk_en   (i_clk_en),
			.i_inc      (inc[p]),
			.i_rd_en    (rd_en[p]),
			.i_rd_addr  (addr[4:0]),
			.o_rd_data  (bank_data[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read sequencing and drop counters.

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			st_d.drop[i] = st_q.drop[i] + mib_pkg::DROP_W'(i_tx_drop[i]);
			st_d.drop[NUM_PORTS+i] = st_q.drop[NUM_PORTS+i]
				+ mib_pkg::DROP_W'(i_rx_drop[i]);
		end
		if (st_q.pend) begin
			st_d.pend = 1'b0;
			st_d.done = 1'b1;
			if (st_q.is_port) begin
				{st_d.hi, st_d.lo} = bank_data[st_q.port];
			end else if (st_q.is_drop) begin
				st_d.hi = '0;
				st_d.lo = st_q.drop[st_q.drop_idx];
			end else begin
				st_d.hi = '0;
				st_d.lo = '0;
			end
		end
		if (take) begin
			st_d.pend     = 1'b1;
			st_d.is_port  = addr_port;
			st_d.is_drop  = addr_drop;
			st_d.port     = addr[6:5];
			st_d.drop_idx = 3'(addr - mib_pkg::DROP_BASE);
			st_d.hi[mib_pkg::VALID_BIT-mib_pkg::HALF_W] = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= '0;
		end else if (i_clk_en) begin
			st_q <= st_d;
		end
	end

	assign o_indirect_data_low_word  = st_q.lo;
	assign o_indirect_data_high_word = st_q.hi;
	assign o_read_done               = st_q.done;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_read_latency: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(take && i_clk_en) ##1 i_clk_en |=> o_read_done)
		else $error("read answer not given one enabled cycle after the command");
	chk_valid_pending: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		st_q.pend |-> !o_indirect_data_high_word[14])
		else $error("valid flag high while a read is pending");
	chk_port_valid: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(o_read_done && st_q.is_port) |-> o_indirect_data_high_word[14])
		else $error("per-port answer lacks the valid flag");
	chk_drop_flags: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(o_read_done && st_q.is_drop) |-> o_indirect_data_high_word == 16'h0000)
		else $error("drop counter answer carries high bits");
	chk_drop_stable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_clk_en && i_tx_drop == '0 && i_rx_drop == '0) |=> $stable(st_q.drop))
		else $error("drop counter changed without a drop event");
	chk_addr_route: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(take && addr >= 10'h020 && addr < 10'h040) |-> (rd_en == NUM_PORTS'(2) || NUM_PORTS < 2))
		else $error("second port address not routed to second bank");
	chk_size_bin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_rx_done[0] && i_rx_len[0] == 12'h040) |-> inc[0][mib_pkg::OFF_RX_BIN64] == 12'h001)
		else $error("64-octet frame not binned");
	chk_late_coll: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		i_tx_late_coll[0] |-> inc[0][mib_pkg::OFF_TX_LATE] == 12'h001)
		else $error("late collision not counted");
	chk_drop_count: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_clk_en && i_tx_drop[0]) |=> st_q.drop[0] == $past(st_q.drop[0]) + 16'h0001)
		else $error("transmit drop of first port not counted");

	cov_port_read: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_read_done && st_q.is_port);
	cov_drop_read: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_read_done && st_q.is_drop);
	cov_unmapped: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_read_done && !st_q.is_port && !st_q.is_drop);
endmodule
`default_nettype wire

// ---- pkg/mib_pkg.sv ----
// Shared constants of the statistics counter block.
`default_nettype none
package mib_pkg;
	// Indirect access control word layout.
	localparam int           CTRL_READ_BIT   = 12;
	localparam int           CTRL_TABLE_LSB  = 10;
	localparam logic [1:0]   CTRL_TABLE_MIB  = 2'h3;
	localparam int           ADDR_W          = 10;
	// Indirect address map.
	localparam logic [9:0]   PORT_SPAN       = 10'h020;
	localparam logic [9:0]   DROP_BASE       = 10'h100;
	// Counter word layout.
	localparam int           OVF_BIT         = 31;
	localparam int           VALID_BIT       = 30;
	localparam int           COUNT_W         = 30;
	localparam int           DROP_W          = 16;
	localparam int           HALF_W          = 16;
	// Frame length limits in octets.
	localparam logic [11:0]  LEN_MIN         = 12'h040;
	localparam logic [11:0]  LEN_127         = 12'h07F;
	localparam logic [11:0]  LEN_255         = 12'h0FF;
	localparam logic [11:0]  LEN_511         = 12'h1FF;
	localparam logic [11:0]  LEN_1023        = 12'h3FF;
	localparam logic [11:0]  LEN_STD_MAX     = 12'h5F2;
	localparam logic [11:0]  LEN_LONG_MAX    = 12'h7D0;
	// Per-port counter offsets.
	localparam int OFF_RX_LO_OCT  = 'h00;
	localparam int OFF_RX_HI_OCT  = 'h01;
	localparam int OFF_RX_UNDER   = 'h02;
	localparam int OFF_RX_FRAG    = 'h03;
	localparam int OFF_RX_OVER    = 'h04;
	localparam int OFF_RX_LONGERR = 'h05;
	localparam int OFF_RX_SYMBOL  = 'h06;
	localparam int OFF_RX_CRC     = 'h07;
	localparam int OFF_RX_ALIGN   = 'h08;
	localparam int OFF_RX_CTRL    = 'h09;
	localparam int OFF_RX_PAUSE   = 'h0A;
	localparam int OFF_RX_BCAST   = 'h0B;
	localparam int OFF_RX_MCAST   = 'h0C;
	localparam int OFF_RX_UCAST   = 'h0D;
	localparam int OFF_RX_BIN64   = 'h0E;
	localparam int OFF_TX_LO_OCT  = 'h14;
	localparam int OFF_TX_HI_OCT  = 'h15;
	localparam int OFF_TX_LATE    = 'h16;
	localparam int OFF_TX_PAUSE   = 'h17;
	localparam int OFF_TX_BCAST   = 'h18;
	localparam int OFF_TX_MCAST   = 'h19;
	localparam int OFF_TX_UCAST   = 'h1A;
	localparam int OFF_TX_DEFER   = 'h1B;
	localparam int OFF_TX_COLL    = 'h1C;
	localparam int OFF_TX_EXCESS  = 'h1D;
	localparam int OFF_TX_SINGLE  = 'h1E;
	localparam int OFF_TX_MULTI   = 'h1F;
	localparam int COUNTERS       = 32;
	localparam int AMT_W          = 12;
endpackage
`default_nettype wire

// ---- rtl/mib_counter_bank.sv ----
// Counter store of one port with clear-on-read and registered read data.
`timescale 1ns/1ns
`default_nettype none
module mib_counter_bank #(
	parameter int COUNTERS = 32,
	parameter int CNT_W    = 30,
	parameter int AMT_W    = 12
) (
	input  wire logic                              i_core_clk,
	input  wire logic                              i_reset_n,
	input  wire logic                              i_clk_en,
	input  wire logic [COUNTERS-1:0][AMT_W-1:0]    i_inc,
	input  wire logic                              i_rd_en,
	input  wire logic [$clog2(COUNTERS)-1:0]       i_rd_addr,
	output logic      [31:0]                       o_rd_data
);
	typedef struct packed {
		logic [COUNTERS-1:0][CNT_W-1:0] cnt;
		logic [COUNTERS-1:0]            ovf;
		logic [31:0]                    rd;
	} bank_state_type;

	bank_state_type st_q;
	bank_state_type st_d;

	if (CNT_W != mib_pkg::COUNT_W || AMT_W > CNT_W || COUNTERS < 2) begin : g_bad
		$error("mib_counter_bank: unsupported parameters");
	end

	always_comb begin
		logic [CNT_W:0] sum;
		sum = '0;
		st_d = st_q;
		for (int i = 0; i < COUNTERS; i++) begin
			sum = {1'b0, st_q.cnt[i]} + (CNT_W+1)'(i_inc[i]);
			if (i_rd_en && i_rd_addr == ($clog2(COUNTERS))'(i)) begin
				st_d.rd[mib_pkg::OVF_BIT]   = st_q.ovf[i];
				st_d.rd[mib_pkg::VALID_BIT] = 1'b1;
				st_d.rd[CNT_W-1:0]          = st_q.cnt[i];
				// Capture and clear in one edge; this edge's increment survives.
				st_d.cnt[i] = CNT_W'(i_inc[i]);
				st_d.ovf[i] = 1'b0;
			end else begin
				st_d.cnt[i] = sum[CNT_W-1:0];
				st_d.ovf[i] = st_q.ovf[i] | sum[CNT_W];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= '0;
		end else if (i_clk_en) begin
			st_q <= st_d;
		end
	end

	assign o_rd_data = st_q.rd;

	chk_clear_read: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_rd_en && i_clk_en) |=> st_q.cnt[$past(i_rd_addr)] == CNT_W'($past(i_inc[i_rd_addr])))
		else $error("read counter was not cleared to the coincident increment");
	chk_read_value: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_rd_en && i_clk_en) |=> o_rd_data[CNT_W-1:0] == $past(st_q.cnt[i_rd_addr]))
		else $error("read data does not hold the counter value");
	chk_ovf_flag: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_rd_en && i_clk_en) |=> o_rd_data[31] == $past(st_q.ovf[i_rd_addr]) && o_rd_data[30])
		else $error("overflow or valid flag wrong in read data");
	cov_overflow: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
		i_rd_en && i_clk_en ##1 o_rd_data[31]);
endmodule
`default_nettype wire

// ---- verif/mib_host_model.sv ----
// Host processor model issuing indirect counter reads.
`timescale 1ns/1ns
`default_nettype none
module mib_host_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_read_done,
	input  wire logic [15:0] i_data_low,
	input  wire logic [15:0] i_data_high,
	output logic             o_ctrl_wr,
	output logic [15:0]      o_ctrl_data
);
	initial begin
		o_ctrl_wr = 1'b0;
		o_ctrl_data = 16'hFFFF;
	end
	////////////////////////////////////////////////////////////////////////////
	// Writes one control word, waits for the answer, then takes high and low.
	task automatic read_word(input logic [15:0] cmd, output logic [31:0] val, output bit got);
		int          n;
		logic [15:0] hi;
		got = 1'b0;
		val = 32'h0;
		@(negedge i_core_clk);
		o_ctrl_data <= cmd;
		o_ctrl_wr <= 1'b1;
		@(negedge i_core_clk);
		o_ctrl_wr <= 1'b0;
		o_ctrl_data <= ~cmd;
		for (n = 0; n < 8 && !got; n++) begin
			if (i_read_done === 1'b1)
				got = 1'b1;
			else
				@(negedge i_core_clk);
		end
		hi = i_data_high;
		for (n = 0; n < 4 && got && cmd[9:8] == 2'h0 && hi[14] !== 1'b1; n++) begin
			@(negedge i_core_clk);
			hi = i_data_high;
		end
		val = {hi, i_data_low};
	endtask
endmodule
`default_nettype wire

// ---- verif/test_mib_statistics_counters.sv ----
// Self-checking bench of the statistics counter block.
`timescale 1ns/1ns
`default_nettype none
module test_mib_statistics_counters;
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	logic             ctrl_wr, done;
	logic [15:0]      ctrl_data, lo_word, hi_word;
	logic [2:0]       rx_done = 3'h0, rx_crc = 3'h0, rx_odd = 3'h0, rx_hi = 3'h0, rx_bc = 3'h0;
	logic [2:0]       rx_mc = 3'h0, rx_ct = 3'h0, rx_pf = 3'h0, tx_done = 3'h0, tx_ok = 3'h0;
	logic [2:0]       tx_hi = 3'h0, tx_bc = 3'h0, tx_mc = 3'h0, tx_def = 3'h0, tx_exc = 3'h0;
	logic [2:0]       tx_col = 3'h0, tx_late = 3'h0, tx_drop = 3'h0, rx_drop = 3'h0;
	logic [2:0]       rx_sym = 3'h0, tx_ps = 3'h0;
	logic             clk_en = 1'b1, long_en = 1'b0;
	logic [2:0][11:0] rx_len = 36'h0, tx_len = 36'h0;
	logic [2:0][3:0]  tx_cc = 12'h0;
	int               exp_cnt [0:95];
	int               exp_drop [0:5];
	int               len_tab [0:9] = '{64, 127, 128, 255, 256, 511, 512, 1023, 1024, 1522};
	int               fail_count = 0, n_tests = 0, cycles = 0, seed = 78584;
	always #4 clk = ~clk;
	mib_host_model host (.i_core_clk(clk), .i_read_done(done), .i_data_low(lo_word),
		.i_data_high(hi_word), .o_ctrl_wr(ctrl_wr), .o_ctrl_data(ctrl_data));
	mib_statistics_counters uut (.i_core_clk(clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
		.i_long_frame_en(long_en), .i_ctrl_wr(ctrl_wr), .i_ctrl_data(ctrl_data),
		.i_rx_done(rx_done), .i_rx_len(rx_len), .i_rx_crc_ok(rx_crc), .i_rx_sym_err(rx_sym),
		.i_rx_odd_bits(rx_odd), .i_rx_high_prio(rx_hi), .i_rx_bcast(rx_bc), .i_rx_mcast(rx_mc),
		.i_rx_ctrl_type(rx_ct), .i_rx_pause_fields(rx_pf), .i_tx_done(tx_done),
		.i_tx_len(tx_len), .i_tx_ok(tx_ok), .i_tx_high_prio(tx_hi), .i_tx_bcast(tx_bc),
		.i_tx_mcast(tx_mc), .i_tx_pause(tx_ps), .i_tx_coll_count(tx_cc), .i_tx_deferred(tx_def),
		.i_tx_excessive(tx_exc), .i_tx_collision(tx_col), .i_tx_late_coll(tx_late),
		.i_tx_drop(tx_drop), .i_rx_drop(rx_drop), .o_indirect_data_low_word(lo_word),
		.o_indirect_data_high_word(hi_word), .o_read_done(done));
	////////////////////////////////////////////////////////////////////////////
	function automatic int bin_of(input int len);
		return (len == 64) ? 14 : (len < 128) ? 15 : (len < 256) ? 16 : (len < 512) ? 17 :
			(len < 1024) ? 18 : 19;
	endfunction
	function automatic logic [31:0] pword(input int v);
		return {2'h1, v[29:0]};
	endfunction
	task automatic check(input string name, input logic [31:0] want, input logic [31:0] got);
		n_tests++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, want, got);
		end
	endtask
	task automatic expect_read(input logic [15:0] cmd, input logic [31:0] want, input bit answer);
		logic [31:0] got;
		bit          seen;
		host.read_word(cmd, got, seen);
		check("read answer", {31'h0, answer}, {31'h0, seen});
		if (answer)
			check("counter word", want, got);
	endtask
	task automatic rx_frame(input int p, input int len);
		logic crc, odd, hi, pf, sym, bad;
		int   k, b, mx;
		crc = ($random(seed) & 3) != 0;
		odd = !crc && ($random(seed) & 1);
		sym = ($random(seed) & 7) == 0;
		hi = $random(seed) & 1;
		pf = $random(seed) & 1;
		k = crc ? $unsigned($random(seed)) % 4 : 2;
		b = p * 32;
		bad = !crc || sym || odd;
		mx = long_en ? 2000 : 1522;
		@(negedge clk);
		rx_done[p] <= 1'b1;
		rx_len[p] <= len[11:0];
		{rx_crc[p], rx_sym[p], rx_odd[p], rx_hi[p], rx_bc[p], rx_mc[p], rx_ct[p], rx_pf[p]} <=
			{crc, sym, odd, hi, k == 0, k == 1 || k == 3, k == 3, pf};
		@(negedge clk);
		rx_done[p] <= 1'b0;
		exp_cnt[b + hi] += len;
		if (len < 64)
			exp_cnt[b + (bad ? 3 : 2)]++;
		if (len > mx && bad)
			exp_cnt[b + 5]++;
		if (len > mx && !bad && len <= 2000)
			exp_cnt[b + 4]++;
		if (len >= 64 && len <= mx) begin
			exp_cnt[b + bin_of(len)]++;
			if (sym)
				exp_cnt[b + 6]++;
			else if (!crc)
				exp_cnt[b + (odd ? 8 : 7)]++;
			if (k == 3 && pf && !bad)
				exp_cnt[b + 10]++;
			if (k < 3 && !bad)
				exp_cnt[b + 11 + k]++;
		end
		if (k == 3)
			exp_cnt[b + 9]++;
	endtask
	task automatic tx_frame(input int p, input int len);
		logic ok, hi, dfr, late, col, txd, rxd, ps;
		int   r, k, c, b;
		r = $random(seed);
		{ok, hi, dfr, late, col, txd, rxd} = r[6:0];
		k = $unsigned($random(seed)) % 3;
		c = $unsigned($random(seed)) % 3;
		ps = k == 1 && ($random(seed) & 3) == 0;
		b = p * 32;
		@(negedge clk);
		tx_done[p] <= 1'b1;
		tx_len[p] <= len[11:0];
		tx_cc[p] <= c[3:0];
		{tx_ok[p], tx_hi[p], tx_bc[p], tx_mc[p], tx_def[p], tx_exc[p], tx_ps[p]} <=
			{ok, hi, k == 0, k == 1, dfr, !ok, ps};
		{tx_late[p], tx_col[p], tx_drop[p], rx_drop[p]} <= {late, col, txd, rxd};
		@(negedge clk);
		{tx_done[p], tx_late[p], tx_col[p], tx_drop[p], rx_drop[p]} <= 5'h00;
		if (ok)
			exp_cnt[b + 20 + hi] += len;
		if (ok && ps)
			exp_cnt[b + 23]++;
		if (ok && !ps)
			exp_cnt[b + 24 + k]++;
		if (ok && c > 0)
			exp_cnt[b + 29 + c]++;
		if (!ok)
			exp_cnt[b + 29]++;
		exp_cnt[b + 27] += dfr;
		exp_cnt[b + 28] += col;
		exp_cnt[b + 22] += late;
		exp_drop[p] += txd;
		exp_drop[p + 3] += rxd;
	endtask
	task automatic late_pulse();
		@(negedge clk);
		tx_late[0] <= 1'b1;
		@(negedge clk);
		tx_late[0] <= 1'b0;
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		int i;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		expect_read(16'h1C0E, pword(0), 1'b1);
		$display("test reset done");
		for (i = 0; i < 30; i++)
			rx_frame(i % 3, len_tab[i % 10]);
		for (i = 0; i < 80; i++) begin
			long_en = i >= 40;
			rx_frame($unsigned($random(seed)) % 3, 40 + $unsigned($random(seed)) % 1980);
			tx_frame($unsigned($random(seed)) % 3, 64 + $unsigned($random(seed)) % 1459);
		end
		for (i = 0; i < 96; i++)
			expect_read(16'(16'h1C00 + i), pword(exp_cnt[i]), 1'b1);
		for (i = 0; i < 96; i++)
			expect_read(16'(16'h1C00 + i), pword(0), 1'b1);
		for (i = 0; i < 12; i++)
			expect_read(16'(16'h1D00 + i % 6), {16'h0, exp_drop[i % 6][15:0]}, 1'b1);
		$display("test traffic done");
		expect_read(16'h1C60, 32'h0, 1'b1);
		expect_read(16'h1D06, 32'h0, 1'b1);
		expect_read(16'h0C05, 32'h0, 1'b0);
		expect_read(16'h1805, 32'h0, 1'b0);
		$display("test address map done");
		late_pulse();
		late_pulse();
		fork
			expect_read(16'h1C16, pword(2), 1'b1);
			late_pulse();
		join
		expect_read(16'h1C16, pword(1), 1'b1);
		$display("test read race done");
		clk_en = 1'b0;
		late_pulse();
		late_pulse();
		@(negedge clk);
		clk_en = 1'b1;
		expect_read(16'h1C16, pword(0), 1'b1);
		late_pulse();
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		expect_read(16'h1C16, pword(0), 1'b1);
		$display("test freeze and reset done");
		stop_test();
	end
endmodule
`default_nettype wire
